//--- rtl/pcl_pkg.sv
package pcl_pkg;

	// timing at 40 MHz (25 ns period)
	localparam int CLK_PERIOD_NS  = 25;
	localparam int RESET_LOW_NS   = 100;
	localparam int BOOT_WAIT_US   = 60;
	localparam int RESET_CYCLES   = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOT_CYCLES    = (BOOT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// i2c quarter bit time: 25 cycles gives 400 kHz scl, so a full load stays near 30k cycles
	localparam int QUARTER_CYCLES = 25;

	// device register offsets
	localparam logic [7:0] REG_PLL_CONTROL     = 8'h05;
	localparam logic [7:0] REG_RSVD_CLOCK_A    = 8'h06;
	localparam logic [7:0] REG_RSVD_CLOCK_B    = 8'h0b;
	localparam logic [7:0] REG_DIV_44K1        = 8'h50;
	localparam logic [7:0] REG_FRAC_LOW_44K1   = 8'h51;
	localparam logic [7:0] REG_FRAC_HIGH_44K1  = 8'h52;
	localparam logic [7:0] REG_DIV_48K         = 8'h61;
	localparam logic [7:0] REG_FRAC_LOW_48K    = 8'h64;
	localparam logic [7:0] REG_FRAC_HIGH_48K   = 8'h65;
	localparam logic [7:0] PLL_CONTROL_VALUE   = 8'ha1;
	localparam int         PLL_ROWS            = 9;

	// clock and ratio selection codes
	localparam logic [1:0] XTAL_10M0  = 2'h0;
	localparam logic [1:0] XTAL_14M31 = 2'h1;
	localparam logic [1:0] XTAL_14M74 = 2'h2;
	localparam logic [1:0] OSR_256    = 2'h0;
	localparam logic [1:0] OSR_384    = 2'h1;
	localparam logic [1:0] OSR_512    = 2'h2;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} pcl_row_s;

	typedef struct packed {
		logic [1:0] xtal;
		logic [1:0] osr;
		logic [6:0] dev_addr;
	} pcl_cfg_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RESET,
		ST_BOOT,
		ST_START,
		ST_BIT,
		ST_ACK,
		ST_STOP,
		ST_NEXT,
		ST_DONE,
		ST_FAIL
	} pcl_state_e;

	typedef struct packed {
		pcl_state_e  state;
		logic [15:0] timer;
		logic [1:0]  phase;
		logic [3:0]  bitn;
		logic [1:0]  byten;
		logic [7:0]  shreg;
		logic [3:0]  row;
		logic        user_phase;
		logic        nack;
		pcl_row_s    urow;
		logic        scl_oe;
		logic        sda_oe;
		logic        rst_n;
		logic        busy;
		logic        done;
		logic        error;
		logic        row_ready;
		logic [1:0]  sda_sync;
	} pcl_state_s;

endpackage

//--- rtl/pcl_loader.sv
// Contract
// R1: pll rows go 6,11,97,80,101,82,100,81, then register 5 gets 161.
// R2: 10 MHz, 256x: 18,3,15,16,169,49,42,60, then 5=161.
// R3: 14.31818 MHz, 256x: 12,3,15,16,187,103,58,119, then 5=161.
// R4: 10 MHz, 384x: 17,3,9,10,110,160,152,186, then 5=161.
// R5: 14.31818 MHz, 384x: 11,3,6,7,3,157,211,157, then 5=161.
// R6: 14.31818 MHz, 512x sends the same nine values as 384x.
// R7: 14.7456 MHz, 256x: 12,3,15,16,85,4,85,0, then 5=161.
// R8: 14.7456 MHz, 384x: 10,3,8,9,64,124,0,0, then 5=161.
// R9: 14.7456 MHz, 512x: 9,2,5,6,0,184,0,0, then 5=161.
// R10: configuration is a list of subaddress/data rows, each one register write.
// R11: each row is start, address+write, subaddress, data, stop.
// R12: advance one row per transaction until list end, then stop.
// R13: wait 60 us of device boot before trusting or writing registers.
// R14: hold device reset low at least 100 ns before release.
// R15: pick sequence from clock and ratio; abort with error on any missing ack.
// R16: each write replaces a whole eight-bit register.
module pcl_loader (
	// clock, reset, enable
	input  wire logic              mclk_in,
	input  wire logic              srst_in,
	input  wire logic              ce_in,
	// user command side
	input  wire logic              start_in,
	input  wire pcl_pkg::pcl_cfg_s cfg_in,
	input  wire pcl_pkg::pcl_row_s user_row_in,
	input  wire logic              user_valid_in,
	input  wire logic              user_last_in,
	output logic                   user_ready_out,
	output logic                   busy_out,
	output logic                   done_out,
	output logic                   error_out,
	// device pins
	output logic                   dev_rst_n_out,
	output logic                   scl_out,
	output logic                   scl_oe_out,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_out
);

	pcl_pkg::pcl_state_s r;
	pcl_pkg::pcl_state_s next_r;

	localparam logic [15:0] RESET_T   = 16'(pcl_pkg::RESET_CYCLES);
	localparam logic [15:0] BOOT_T    = 16'(pcl_pkg::BOOT_CYCLES);
	localparam logic [15:0] QUARTER_T = 16'(pcl_pkg::QUARTER_CYCLES - 1);

	// fixed pll table; row index 0..8
	function automatic pcl_pkg::pcl_row_s pll_row(input logic [1:0] xtal, input logic [1:0] osr,
		input logic [3:0] idx);
		logic [7:0] v [0:7];
		pcl_pkg::pcl_row_s row;
		v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		row = '0;
		unique case ({xtal, osr})
			{pcl_pkg::XTAL_10M0, pcl_pkg::OSR_256}:   // see R2
				v = '{8'h12, 8'h03, 8'h0f, 8'h10, 8'ha9, 8'h31, 8'h2a, 8'h3c};
			{pcl_pkg::XTAL_14M31, pcl_pkg::OSR_256}:  // see R3
				v = '{8'h0c, 8'h03, 8'h0f, 8'h10, 8'hbb, 8'h67, 8'h3a, 8'h77};
			{pcl_pkg::XTAL_10M0, pcl_pkg::OSR_384}:   // see R4
				v = '{8'h11, 8'h03, 8'h09, 8'h0a, 8'h6e, 8'ha0, 8'h98, 8'hba};
			{pcl_pkg::XTAL_14M31, pcl_pkg::OSR_384},
			{pcl_pkg::XTAL_14M31, pcl_pkg::OSR_512}:  // see R5 see R6
				v = '{8'h0b, 8'h03, 8'h06, 8'h07, 8'h03, 8'h9d, 8'hd3, 8'h9d};
			{pcl_pkg::XTAL_14M74, pcl_pkg::OSR_256}:  // see R7
				v = '{8'h0c, 8'h03, 8'h0f, 8'h10, 8'h55, 8'h04, 8'h55, 8'h00};
			{pcl_pkg::XTAL_14M74, pcl_pkg::OSR_384}:  // see R8
				v = '{8'h0a, 8'h03, 8'h08, 8'h09, 8'h40, 8'h7c, 8'h00, 8'h00};
			{pcl_pkg::XTAL_14M74, pcl_pkg::OSR_512}:  // see R9
				v = '{8'h09, 8'h02, 8'h05, 8'h06, 8'h00, 8'hb8, 8'h00, 8'h00};
			// 10 MHz at 512x has no table: the check in ST_IDLE refuses it
			default:
				v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		endcase
		unique case (idx) // see R1
			4'h0: row = '{pcl_pkg::REG_RSVD_CLOCK_A, v[0]};
			4'h1: row = '{pcl_pkg::REG_RSVD_CLOCK_B, v[1]};
			4'h2: row = '{pcl_pkg::REG_DIV_48K, v[2]};
			4'h3: row = '{pcl_pkg::REG_DIV_44K1, v[3]};
			4'h4: row = '{pcl_pkg::REG_FRAC_HIGH_48K, v[4]};
			4'h5: row = '{pcl_pkg::REG_FRAC_HIGH_44K1, v[5]};
			4'h6: row = '{pcl_pkg::REG_FRAC_LOW_48K, v[6]};
			4'h7: row = '{pcl_pkg::REG_FRAC_LOW_44K1, v[7]};
			default: row = '{pcl_pkg::REG_PLL_CONTROL, pcl_pkg::PLL_CONTROL_VALUE};
		endcase
		return row;
	endfunction

	function automatic logic valid_combo(input logic [1:0] xtal, input logic [1:0] osr);
		return (xtal <= pcl_pkg::XTAL_14M74) && (osr <= pcl_pkg::OSR_512) &&
			!(xtal == pcl_pkg::XTAL_10M0 && osr == pcl_pkg::OSR_512);
	endfunction

	always_comb
	begin
		pcl_pkg::pcl_row_s cur;
		next_r = r;
		cur = r.user_phase ? r.urow : pll_row(cfg_in.xtal, cfg_in.osr, r.row);
		next_r.sda_sync = {r.sda_sync[0], sda_in};
		next_r.row_ready = 1'b0;
		if (r.timer != 16'h0000)
			next_r.timer = r.timer - 16'h0001;
		unique case (r.state)
			pcl_pkg::ST_IDLE:
			begin
				if (start_in)
				begin
					next_r.done = 1'b0;
					next_r.error = 1'b0;
					if (!valid_combo(cfg_in.xtal, cfg_in.osr))
					begin
						next_r.state = pcl_pkg::ST_FAIL; // see R15
					end
					else
					begin
						next_r.busy = 1'b1;
						next_r.rst_n = 1'b0;
						next_r.timer = RESET_T;
						next_r.row = 4'h0;
						next_r.user_phase = 1'b0;
						next_r.state = pcl_pkg::ST_RESET;
					end
				end
			end
			pcl_pkg::ST_RESET:
				if (r.timer == 16'h0000)
				begin
					next_r.rst_n = 1'b1; // see R14
					next_r.timer = BOOT_T;
					next_r.state = pcl_pkg::ST_BOOT;
				end
			pcl_pkg::ST_BOOT:
				if (r.timer == 16'h0000)
				begin
					next_r.state = pcl_pkg::ST_START; // see R13
				end
			pcl_pkg::ST_START:
				// sda falls while scl high, then scl falls
				if (r.timer == 16'h0000)
				begin
					next_r.timer = QUARTER_T;
					next_r.phase = r.phase + 2'h1;
					if (r.phase == 2'h0)
						next_r.sda_oe = 1'b1;
					if (r.phase == 2'h1)
					begin
						next_r.scl_oe = 1'b1;
						next_r.phase = 2'h0;
						next_r.byten = 2'h0;
						next_r.bitn = 4'h0;
						next_r.shreg = {cfg_in.dev_addr, 1'b0}; // see R11
						next_r.state = pcl_pkg::ST_BIT;
					end
				end
			pcl_pkg::ST_BIT, pcl_pkg::ST_ACK:
				// phases: 0 set data, 1 raise scl, 2 sample, 3 drop scl
				if (r.timer == 16'h0000)
				begin
					next_r.timer = QUARTER_T;
					next_r.phase = r.phase + 2'h1;
					unique case (r.phase)
						2'h0: next_r.sda_oe = (r.state == pcl_pkg::ST_BIT) ? !r.shreg[7] : 1'b0;
						2'h1: next_r.scl_oe = 1'b0;
						2'h2: next_r.nack = r.sda_sync[1];
						2'h3:
						begin
							next_r.scl_oe = 1'b1;
							if (r.state == pcl_pkg::ST_BIT)
							begin
								next_r.shreg = {r.shreg[6:0], 1'b0};
								next_r.bitn = r.bitn + 4'h1;
								if (r.bitn == 4'h7)
									next_r.state = pcl_pkg::ST_ACK;
							end
							else if (r.nack)
							begin
								// error shows only once the stop has freed the bus
								next_r.state = pcl_pkg::ST_STOP; // see R15
							end
							else if (r.byten == 2'h2)
							begin
								next_r.state = pcl_pkg::ST_STOP;
							end
							else
							begin
								next_r.byten = r.byten + 2'h1;
								next_r.bitn = 4'h0;
								// whole byte replaces the register
								next_r.shreg = (r.byten == 2'h0) ? cur.addr : cur.data; // see R16
								next_r.state = pcl_pkg::ST_BIT;
							end
						end
						default: next_r.phase = 2'h0;
					endcase
				end
			pcl_pkg::ST_STOP:
				if (r.timer == 16'h0000)
				begin
					next_r.timer = QUARTER_T;
					next_r.phase = r.phase + 2'h1;
					unique case (r.phase)
						2'h0: next_r.sda_oe = 1'b1;
						2'h1: next_r.scl_oe = 1'b0;
						2'h2: next_r.sda_oe = 1'b0;
						default:
						begin
							next_r.phase = 2'h0;
							next_r.state = r.nack ? pcl_pkg::ST_FAIL : pcl_pkg::ST_NEXT;
						end
					endcase
				end
			pcl_pkg::ST_NEXT:
			begin
				// one transaction per row, then the user file rows
				if (!r.user_phase && r.row != 4'(pcl_pkg::PLL_ROWS - 1))
				begin
					next_r.row = r.row + 4'h1; // see R12
					next_r.state = pcl_pkg::ST_START;
				end
				else if (!r.user_phase || !r.nack && !r.done)
				begin
					next_r.user_phase = 1'b1;
					if (r.user_phase && r.row == 4'hf)
					begin
						next_r.state = pcl_pkg::ST_DONE;
					end
					else if (user_valid_in)
					begin
						next_r.row_ready = 1'b1; // see R10
						next_r.urow = user_row_in;
						next_r.row = user_last_in ? 4'hf : 4'h0;
						next_r.state = pcl_pkg::ST_START;
					end
				end
			end
			pcl_pkg::ST_DONE:
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1; // see R12
				next_r.state = pcl_pkg::ST_IDLE;
			end
			pcl_pkg::ST_FAIL:
			begin
				next_r.busy = 1'b0;
				next_r.error = 1'b1;
				next_r.state = pcl_pkg::ST_IDLE;
			end
			default: next_r.state = pcl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			r <= '0;
			r.state <= pcl_pkg::ST_IDLE;
			r.rst_n <= 1'b1;
			r.sda_sync <= 2'h3;
		end
		else if (ce_in)
		begin
			r <= next_r;
		end
	end

	// open drain: only ever drive low
	assign scl_out        = 1'b0;
	assign sda_out        = 1'b0;
	assign scl_oe_out     = r.scl_oe;
	assign sda_oe_out     = r.sda_oe;
	assign dev_rst_n_out  = r.rst_n;
	assign busy_out       = r.busy;
	assign done_out       = r.done;
	assign error_out      = r.error;
	assign user_ready_out = r.row_ready;

endmodule

//--- bench/pcl_loader_monitor.sv
module pcl_loader_monitor (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// user side
	input wire logic start_in,
	input wire logic user_valid_in,
	input wire logic user_ready_out,
	input wire logic busy_out,
	input wire logic error_out,
	// device pins
	input wire logic dev_rst_n_out,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int boot_cnt;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_rst_low;
		!dev_rst_n_out [*4];
	endsequence

	// saturates so that every later start of a row still passes
	always_ff @(posedge mclk_in)
	begin
		if (!dev_rst_n_out)
			boot_cnt <= 0;
		else if (boot_cnt < 4000)
			boot_cnt <= boot_cnt + 1;
	end

	reset_quiet_a: assert property ($fell(srst_in) |->
		!busy_out && !scl_oe_out && !sda_oe_out && dev_rst_n_out) else $error("outputs not quiet");
	start_busy_a: assert property ($rose(busy_out) |-> $past(start_in))
		else $error("busy without start");
	dev_reset_low_a: assert property ($fell(dev_rst_n_out) |-> s_rst_low)
		else $error("device reset too short");
	boot_wait_a: assert property ($rose(sda_oe_out) |-> boot_cnt >= pcl_pkg::BOOT_CYCLES)
		else $error("bus used during boot");
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("bus line driven high");
	error_sticky_a: assert property (error_out && !start_in |=> error_out)
		else $error("error dropped");
	abort_release_a: assert property ($rose(error_out) |->
		!busy_out && !scl_oe_out && !sda_oe_out) else $error("abort left bus held");
	sequence s_ready_once;
		busy_out ##1 !user_ready_out;
	endsequence

	// a row is taken only when offered, and the taken pulse lasts one cycle
	ready_pulse_a: assert property (user_ready_out |-> $past(user_valid_in) ##0 s_ready_once)
		else $error("bad row handshake");
endmodule

bind pcl_loader pcl_loader_monitor i_pcl_loader_monitor (.mclk_in(mclk_in), .srst_in(srst_in),
	.start_in(start_in), .user_valid_in(user_valid_in), .user_ready_out(user_ready_out),
	.busy_out(busy_out), .error_out(error_out), .dev_rst_n_out(dev_rst_n_out),
	.scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

//--- bench/pcl_device_model.sv
module pcl_device_model #(
	parameter logic [6:0] DEV_ADDR = 7'h1a // arbitrary bus address
) (
	// device pins
	input  wire logic rst_n_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]        regs [256];
	logic [7:0]        sh;
	logic [7:0]        sub;
	logic              sel;
	logic              early = 0;
	int                bitc;
	int                byten = -1;
	realtime           up_t;
	pcl_pkg::pcl_row_s log_q [$];

	initial sda_oe_out = 0;
	always @(posedge rst_n_in) up_t = $realtime;
	// a start inside the boot window is flagged for the bench
	always @(negedge sda_in)
		if (scl_in === 1'b1)
		begin
			bitc = 0;
			byten = 0;
			if ($realtime - up_t < 60000.0) early = 1;
		end
	always @(posedge sda_in)
		if (scl_in === 1'b1) byten = -1;
	always @(posedge scl_in)
		if (byten >= 0 && bitc < 8)
		begin
			sh = {sh[6:0], sda_in};
			bitc++;
		end
	always @(negedge scl_in)
		if (bitc == 9)
		begin
			sda_oe_out = 0;
			bitc = 0;
			byten++;
		end
		else if (bitc == 8)
		begin
			if (byten == 0) sel = (sh == {DEV_ADDR, 1'b0});
			if (byten == 1) sub = sh;
			if (byten == 2 && sel)
			begin
				regs[sub] = sh;
				log_q.push_back({sub, sh});
			end
			sda_oe_out = sel;
			bitc = 9;
		end
endmodule

//--- bench/pcl_loader_test.sv
module pcl_loader_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              mclk_in;
	logic              srst_in = 1;
	logic              start_in = 0;
	logic              user_valid_in = 0;
	logic              user_last_in = 0;
	logic              sda_w;
	logic              dev_sda_oe;
	logic              user_ready_out, busy_out, done_out, error_out;
	logic              dev_rst_n_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
	pcl_pkg::pcl_cfg_s cfg_in = '0;
	pcl_pkg::pcl_row_s user_row_in = 16'h425a;
	int                error_cnt = 0;
	int                compares = 0;
	int                base;
	int                seen;
	pcl_pkg::pcl_row_s exp_row;
	// pll register order, then the user rows that each load offers
	logic [7:0]        exp_addr [9] = '{8'h06, 8'h0b, 8'h61, 8'h50, 8'h65, 8'h52, 8'h64, 8'h51,
		8'h05};
	pcl_pkg::pcl_row_s user_rows [2] = '{16'h425a, 16'h43c7};
	// ordinary loads: configuration, user rows offered, pll data bytes in write order
	pcl_pkg::pcl_cfg_s case_cfg [2] = '{'{2'h2, 2'h2, 7'h1a}, '{2'h0, 2'h0, 7'h1a}};
	int                case_users [2] = '{1, 2};
	logic [71:0]       case_data [2] = '{72'h09_02_05_06_00_b8_00_00_a1,
		72'h12_03_0f_10_a9_31_2a_3c_a1};

	// pull-up: low while either side pulls
	assign sda_w = !(sda_oe_out || dev_sda_oe);
	pcl_loader i_pcl_loader (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1),
		.start_in(start_in), .cfg_in(cfg_in), .user_row_in(user_row_in),
		.user_valid_in(user_valid_in), .user_last_in(user_last_in), .user_ready_out(user_ready_out),
		.busy_out(busy_out), .done_out(done_out), .error_out(error_out),
		.dev_rst_n_out(dev_rst_n_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
	pcl_device_model i_pcl_device_model (.rst_n_in(dev_rst_n_out), .scl_in(!scl_oe_out),
		.sda_in(sda_w), .sda_oe_out(dev_sda_oe));

	initial
	begin
		mclk_in = 0;
		forever #12.5 mclk_in = !mclk_in;
	end

	task wrap_up;
		$display("mismatches %0d of %0d compares", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask

	task rst3;
		@(posedge mclk_in);
		srst_in <= 1;
		repeat (3) @(posedge mclk_in);
		srst_in <= 0;
	endtask

	// reads at the edge see the value of the cycle before it, so a pulse is not missed
	task run(input pcl_pkg::pcl_cfg_s c, input int users, input int bound);
		int n;
		int taken;
		taken = 0;
		@(posedge mclk_in);
		cfg_in <= c;
		start_in <= 1;
		user_row_in <= user_rows[0];
		user_last_in <= (users == 1);
		user_valid_in <= (users > 0);
		@(posedge mclk_in);
		start_in <= 0;
		for (n = 0; n < bound && done_out !== 1'b1 && error_out !== 1'b1; n++)
		begin
			@(posedge mclk_in);
			if (user_ready_out === 1'b1)
			begin
				taken++;
				// offer the next row, or withdraw once the last one is taken
				if (taken < users)
				begin
					user_row_in <= user_rows[taken];
					user_last_in <= (taken == users - 1);
				end
				else
					user_valid_in <= 0;
			end
		end
		if (n == bound)
		begin
			$display("unexpected timeout expected end seen none");
			error_cnt++;
			wrap_up;
		end
		@(negedge mclk_in);
	endtask

	initial
	begin
		rst3;
		@(negedge mclk_in);
		chk("idle_pins", 16'h0001, {busy_out, scl_oe_out, sda_oe_out, dev_rst_n_out});
		for (int k = 0; k < 2; k++)
		begin
			rst3;
			base = i_pcl_device_model.log_q.size();
			run(case_cfg[k], case_users[k], 40000);
			seen = i_pcl_device_model.log_q.size() - base;
			chk("load_done", 16'h0002, {error_out, done_out, busy_out});
			chk("row_count", 16'(9 + case_users[k]), 16'(seen));
			for (int i = 0; i < 9 + case_users[k] && i < seen; i++)
			begin
				if (i < 9)
					exp_row = {exp_addr[i], case_data[k][71 - 8 * i -: 8]};
				else
					exp_row = user_rows[i - 9];
				chk("row", exp_row, i_pcl_device_model.log_q[base + i]);
			end
			chk("pll_control", 16'h00a1, {8'h00, i_pcl_device_model.regs[5]});
		end
		rst3;
		run('{2'h0, 2'h2, 7'h1a}, 0, 50);
		chk("no_table", 16'h0002, {error_out, busy_out});
		rst3;
		base = i_pcl_device_model.log_q.size();
		run('{2'h2, 2'h2, 7'h2b}, 1, 20000);
		seen = i_pcl_device_model.log_q.size() - base;
		chk("nack_abort", 16'h0002, {error_out, done_out});
		chk("nack_rows", 16'h0000, 16'(seen));
		chk("boot_wait", 16'h0000, {15'h0, i_pcl_device_model.early});
		wrap_up;
	end
endmodule
